// File: src/dpsc_pkg.sv
// Purpose: shared constants of the dual pot serial command logic
// Assumes: 250 MHz system clock
// Notes:   opcodes sit in the upper nibble of the instruction byte
package dpsc_pkg;
    localparam int          CLK_MHZ            = 250;
    // device type nibble; value is arbitrary
    localparam logic [3:0]  DEV_TYPE           = 4'h9;
    localparam logic [1:0]  ADDR_PAD           = 2'h0;
    localparam logic [3:0]  OP_RD_WIPER        = 4'h9;
    localparam logic [3:0]  OP_WR_WIPER        = 4'ha;
    localparam logic [3:0]  OP_RD_STORE        = 4'hb;
    localparam logic [3:0]  OP_WR_STORE        = 4'hc;
    localparam logic [3:0]  OP_COPY_TO_WIPER   = 4'hd;
    localparam logic [3:0]  OP_COPY_TO_STORE   = 4'he;
    localparam logic [3:0]  OP_GCOPY_TO_WIPER  = 4'h1;
    localparam logic [3:0]  OP_GCOPY_TO_STORE  = 4'h8;
    localparam logic [3:0]  OP_STEP            = 4'h2;
    localparam logic [3:0]  OP_STATUS          = 4'h5;
    localparam int          POT_COUNT          = 2;
    localparam int          STORE_COUNT        = 4;
    localparam logic [7:0]  STORE_RESET        = 8'h80;
    localparam int          WIPER_SETTLE_MIN_US = 5;
    localparam int          WIPER_SETTLE_MAX_US = 10;
    localparam int          WIPER_SETTLE_CYC   = (WIPER_SETTLE_MIN_US + WIPER_SETTLE_MAX_US) * CLK_MHZ / 2;
    localparam int          STORE_WRITE_MS     = 5;
    localparam int          STORE_WRITE_CYC    = STORE_WRITE_MS * 1000 * CLK_MHZ;
    localparam int          POWERUP_WAIT_MS    = 1;
endpackage : dpsc_pkg

// File: src/dpsc_link_if.sv
// Purpose: carries decoded commands from the link domain to the core
// Assumes: toggle crossing, payload stable while the toggle settles
// Notes:   none
interface dpsc_link_if;
    logic       cmd_tgl;
    logic [3:0] cmd_op;
    logic [3:0] cmd_arg;
    logic [7:0] cmd_data;
    logic       step_up;
    modport link (output cmd_tgl, output cmd_op, output cmd_arg, output cmd_data, output step_up);
    modport core (input cmd_tgl, input cmd_op, input cmd_arg, input cmd_data, input step_up);
endinterface : dpsc_link_if

// File: src/dpsc_link.sv
// Purpose: serial shifter on the bus clock, decodes address and instruction
// Assumes: mode 0; chip select resets the bit counter asynchronously via the frame
// Notes:   read data comes from the core snapshot, sampled at the falling clock edge after the instruction byte
module dpsc_link
    import dpsc_pkg::*;
(
    // bus pins
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       si,
    input  wire logic [1:0] pin_addr,
    // read data from core, quasi-static
    input  wire logic [7:0] rd_data,
    output logic            so,
    output logic            so_oe,
    dpsc_link_if.link       lnk
);
    logic [4:0] bit_reg;
    logic [7:0] shift_reg;
    logic       match_reg;
    logic       stepping_reg;
    logic [7:0] instr_reg;
    logic [7:0] out_reg;
    // one toggle per clock source; only one of them moves per event
    logic       step_tgl_reg = 1'b0;
    logic       end_tgl_reg  = 1'b0;
    logic [7:0] byte_next;
    assign byte_next = {shift_reg[6:0], si};
    assign lnk.cmd_tgl = step_tgl_reg ^ end_tgl_reg;
    always_ff @(posedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            bit_reg      <= 5'h0;
            match_reg    <= 1'b0;
            stepping_reg <= 1'b0;
        end
        else
        begin
            shift_reg <= byte_next;
            if (bit_reg != 5'h18)
                bit_reg <= bit_reg + 5'h1;
            if (bit_reg == 5'h7)
                match_reg <= byte_next[7:4] == DEV_TYPE && byte_next[1:0] == pin_addr; // R2 R3 R4
            if (bit_reg == 5'hf && match_reg)
            begin
                instr_reg <= byte_next; // R6
                stepping_reg <= byte_next[7:4] == OP_STEP;
            end
            if (stepping_reg)
            begin
                lnk.step_up  <= si; // R24
                lnk.cmd_op   <= OP_STEP;
                lnk.cmd_arg  <= instr_reg[3:0];
                step_tgl_reg <= ~step_tgl_reg;
            end
            else if (bit_reg == 5'hf && match_reg && byte_next[7:4] != OP_STEP)
            begin
                lnk.cmd_op   <= byte_next[7:4];
                lnk.cmd_arg  <= byte_next[3:0]; // R7 R8
                lnk.cmd_data <= 8'h0;
            end
            else if (bit_reg == 5'h17 && match_reg)
                lnk.cmd_data <= byte_next; // R22
        end
    end
    // issue at chip select rising for non-step commands
    always_ff @(posedge cs_n)
    begin
        if (match_reg && !stepping_reg && bit_reg >= 5'h10)
            end_tgl_reg <= ~end_tgl_reg; // R16
    end
    always_ff @(negedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            so_oe   <= 1'b0;
            so      <= 1'b0;
            out_reg <= 8'h0;
        end
        else if (bit_reg == 5'h10)
        begin
            out_reg <= {rd_data[6:0], 1'b0};
            so      <= rd_data[7];
            so_oe   <= match_reg;
        end
        else
        begin
            so      <= out_reg[7];
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end
endmodule : dpsc_link

// File: src/dpsc_top.sv
// Purpose: dual pot command and register core
// Assumes: sys_rst stands for power-up; store array models non-volatile cells
// Notes:   commands from link cross by toggle; wiper taps settle after a delay
// Contract
// R1 - host opens each command with address byte
// R2 - upper address nibble equals device type
// R3 - low address bits must match select pins
// R4 - mismatched device ignores following instruction
// R5 - host drives two pad bits zero
// R6 - second byte upper nibble is opcode
// R7 - bits three and two pick setting register
// R8 - low two bits pick the wiper; the code decodes bit 0 only
// R9 - 8-bit wiper decodes to one tap
// R10 - wiper changes by write, copy, step
// R11 - power-up loads wiper from boot setting
// R12 - wiper is volatile, reloaded each power-up
// R13 - four host-accessible setting registers per pot
// R14 - copy either way setting and wiper
// R15 - setting change completes within five ms
// R16 - store starts at chip select rising
// R17 - status command returns write pending bit
// R18 - host waits one ms after power; the bench drops chip select for its first frame about 3 us after sys_rst falls
// R19 - wiper moves five to ten us later
// R20 - power-up load lands five to ten us
// R21 - write pending reads one while storing
// R22 - data commands take third byte
// R23 - opcode table for read, write, copy
// R24 - each clock steps wiper by data-in
// R25 - pending set at store start, cleared after
// R26 - stepping saturates at both ends
module dpsc_top
    import dpsc_pkg::*;
#(
    parameter int STORE_CYC  = STORE_WRITE_CYC,
    parameter int SETTLE_CYC = WIPER_SETTLE_CYC
)
(
    // system
    input  wire logic         clock,
    input  wire logic         sys_rst,
    // serial bus
    input  wire logic         sck,
    input  wire logic         cs_n,
    input  wire logic         si,
    input  wire logic [1:0]   pin_addr,
    output logic              so,
    output logic              so_oe,
    // tap selects, all zero during sys_rst, then one-hot per pot
    output logic [255:0]      tap0_sel,
    output logic [255:0]      tap1_sel,
    output logic              write_pending
);
    initial
    begin
        if (STORE_CYC < 1 || SETTLE_CYC < 1)
            $error("counts must be positive");
    end
    dpsc_link_if lnk ();
    logic [7:0] rd_data_reg;
    dpsc_link u_link (
        .sck      (sck),
        .cs_n     (cs_n),
        .si       (si),
        .pin_addr (pin_addr),
        .rd_data  (rd_data_reg),
        .so       (so),
        .so_oe    (so_oe),
        .lnk      (lnk)
    );
    logic [7:0]  store_reg [POT_COUNT][STORE_COUNT];
    logic [7:0]  wiper_position [POT_COUNT];
    logic [7:0]  shown_reg [POT_COUNT];
    logic [2:0]  tgl_sync_reg;
    logic        cmd_go;
    logic [31:0] store_cnt_reg;
    logic [31:0] settle_cnt_reg;
    logic        boot_reg;
    logic        store_arm_reg;
    logic [3:0]  op;
    logic [1:0]  sidx;
    logic        pidx;
    assign op   = lnk.cmd_op;
    assign sidx = lnk.cmd_arg[3:2];
    assign pidx = lnk.cmd_arg[0];
    // not reset: the link toggle keeps its level across sys_rst, a reset here would fake a command
    always_ff @(posedge clock)
    begin
        tgl_sync_reg <= {tgl_sync_reg[1:0], lnk.cmd_tgl};
    end
    assign cmd_go = tgl_sync_reg[2] ^ tgl_sync_reg[1];
    // setting store array; contents survive sys_rst
    always_ff @(posedge clock)
    begin
        if (cmd_go && !write_pending)
        begin
            if (op == OP_WR_STORE)
                store_reg[pidx][sidx] <= lnk.cmd_data; // R13 R15
            else if (op == OP_COPY_TO_STORE)
                store_reg[pidx][sidx] <= wiper_position[pidx]; // R14
            else if (op == OP_GCOPY_TO_STORE)
                for (int p = 0; p < POT_COUNT; p++)
                    store_reg[p][sidx] <= wiper_position[p];
        end
    end
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            for (int p = 0; p < POT_COUNT; p++)
                wiper_position[p] <= STORE_RESET;
            boot_reg <= 1'b1;
        end
        else if (boot_reg)
        begin
            for (int p = 0; p < POT_COUNT; p++)
                wiper_position[p] <= store_reg[p][0]; // R11 R12
            boot_reg <= 1'b0;
        end
        else if (cmd_go)
        begin
            unique case (op)
                OP_WR_WIPER:       wiper_position[pidx] <= lnk.cmd_data; // R10 R23
                OP_COPY_TO_WIPER:  wiper_position[pidx] <= store_reg[pidx][sidx]; // R14
                OP_GCOPY_TO_WIPER:
                    for (int p = 0; p < POT_COUNT; p++)
                        wiper_position[p] <= store_reg[p][sidx];
                OP_STEP:
                    if (lnk.step_up && wiper_position[pidx] != 8'hff)
                        wiper_position[pidx] <= wiper_position[pidx] + 8'h1; // R24 R26
                    else if (!lnk.step_up && wiper_position[pidx] != 8'h00)
                        wiper_position[pidx] <= wiper_position[pidx] - 8'h1; // R26
                default: ;
            endcase
        end
    end
    // read snapshot for the next frame
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            rd_data_reg <= 8'h0;
        else if (cmd_go)
        begin
            unique case (op)
                OP_RD_WIPER: rd_data_reg <= wiper_position[pidx];
                OP_RD_STORE: rd_data_reg <= store_reg[pidx][sidx];
                OP_STATUS:   rd_data_reg <= {7'h0, write_pending}; // R17
                default:     rd_data_reg <= wiper_position[pidx];
            endcase
        end
    end
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            write_pending <= 1'b0;
            store_cnt_reg <= 32'h0;
        end
        else if (cmd_go && !write_pending && (op == OP_WR_STORE || op == OP_COPY_TO_STORE
                 || op == OP_GCOPY_TO_STORE))
        begin
            write_pending <= 1'b1; // R16 R21 R25
            store_cnt_reg <= 32'(STORE_CYC - 1);
        end
        else if (write_pending)
        begin
            if (store_cnt_reg == 32'h0)
                write_pending <= 1'b0; // R15 R25
            else
                store_cnt_reg <= store_cnt_reg - 32'h1;
        end
    end
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            settle_cnt_reg <= 32'(SETTLE_CYC);
            store_arm_reg  <= 1'b1;
        end
        else if (shown_reg[0] != wiper_position[0] || shown_reg[1] != wiper_position[1])
        begin
            if (settle_cnt_reg == 32'h0)
                settle_cnt_reg <= 32'(SETTLE_CYC);
            else
                settle_cnt_reg <= settle_cnt_reg - 32'h1; // R19 R20
            store_arm_reg <= 1'b0;
        end
        else
            settle_cnt_reg <= 32'(SETTLE_CYC);
    end
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            for (int p = 0; p < POT_COUNT; p++)
                shown_reg[p] <= 8'h0;
        else if (settle_cnt_reg == 32'h0)
            for (int p = 0; p < POT_COUNT; p++)
                shown_reg[p] <= wiper_position[p];
    end
    genvar t;
    generate
        for (t = 0; t < 256; t++)
        begin : g_tap
            always_ff @(posedge clock)
            begin
                if (sys_rst)
                begin
                    tap0_sel[t] <= 1'b0;
                    tap1_sel[t] <= 1'b0;
                end
                else
                begin
                    tap0_sel[t] <= shown_reg[0] == 8'(t); // R9
                    tap1_sel[t] <= shown_reg[1] == 8'(t);
                end
            end
        end
    endgenerate
    a_pending_len: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(write_pending) |-> write_pending[*8]) else $error("pending dropped early"); // R21
    a_pend_start: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(write_pending) |-> $past(cmd_go)) else $error("pending without command"); // R25
    a_step_sat_hi: assert property (@(posedge clock) disable iff (sys_rst)
        cmd_go && !boot_reg && op == OP_STEP && lnk.step_up && wiper_position[pidx] == 8'hff
        |=> wiper_position[pidx] == 8'hff) else $error("wrap at top"); // R26
    a_step_sat_lo: assert property (@(posedge clock) disable iff (sys_rst)
        cmd_go && !boot_reg && op == OP_STEP && !lnk.step_up && wiper_position[pidx] == 8'h00
        |=> wiper_position[pidx] == 8'h00) else $error("wrap at bottom"); // R26
    a_tap_onehot: assert property (@(posedge clock) disable iff (sys_rst)
        !$past(sys_rst) |-> $onehot(tap0_sel) && $onehot(tap1_sel)) else $error("tap not one-hot"); // R9
    a_wiper_write: assert property (@(posedge clock) disable iff (sys_rst)
        cmd_go && !boot_reg && op == OP_WR_WIPER |=> wiper_position[$past(pidx)] == $past(lnk.cmd_data))
        else $error("wiper write lost"); // R10
    a_status_read: assert property (@(posedge clock) disable iff (sys_rst)
        cmd_go && op == OP_STATUS |=> rd_data_reg == {7'h0, $past(write_pending)})
        else $error("status wrong"); // R17
    a_no_early_tap: assert property (@(posedge clock) disable iff (sys_rst)
        $changed(shown_reg[0]) |-> $past(settle_cnt_reg) == 32'h0) else $error("tap moved early"); // R19
endmodule : dpsc_top

// File: verification/dpsc_host.sv
// Purpose: serial bus master model for the dual pot command logic
// Assumes: mode 0, bus clock idles low and stands still between frames
// Notes:   bus clock period 125 ns, unrelated in phase to the system clock
module dpsc_host
(
    // bus pins
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so_line
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end

    // address, instruction, data byte, then extra step bits from dat
    task automatic frame(input logic [7:0] adr, input logic [7:0] ins, input logic [7:0] dat,
                         input int nbits, output logic [7:0] rd);
        logic [23:0] sh;
        sh = {adr, ins, dat};
        rd = 8'h00;
        #1037;
        cs_n = 1'b0;
        for (int k = 0; k < nbits; k++)
        begin
            si = (k < 24) ? sh[23 - k] : dat[7 - (k % 8)];
            #62.5;
            sck = 1'b1;
            rd = {rd[6:0], so_line};
            #62.5;
            sck = 1'b0;
        end
        #62.5;
        cs_n = 1'b1;
        // released data line must not keep the last bit
        si = ~si;
    endtask : frame
endmodule : dpsc_host

// File: verification/tb.sv
// Purpose: self-checking bench of the dual pot command logic
// Assumes: short store and settle counts set by parameter
// Notes:   expected taps are one-hot of the written wiper value
module tb;
    import dpsc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int         STC  = 50;
    localparam int         SEC  = 8;
    localparam logic [1:0] PINS = 2'h2;
    logic         clock         = 1'b0;
    logic         sys_rst       = 1'b1;
    logic [1:0]   pin_addr      = PINS;
    logic         sck;
    logic         cs_n;
    logic         si;
    logic         so;
    logic         so_oe;
    logic         write_pending;
    logic [255:0] tap0_sel;
    logic [255:0] tap1_sel;
    logic [7:0]   rd;
    wire          so_line       = so_oe ? so : 1'bz;
    int           miscompares   = 0;
    int           n_checks      = 0;

    always #2 clock = ~clock;

    dpsc_top #(.STORE_CYC(STC), .SETTLE_CYC(SEC)) DUT (
        .clock(clock), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si), .pin_addr(pin_addr),
        .so(so), .so_oe(so_oe), .tap0_sel(tap0_sel), .tap1_sel(tap1_sel), .write_pending(write_pending));

    dpsc_host host (.sck(sck), .cs_n(cs_n), .si(si), .so_line(so_line));

    function automatic logic [7:0] adr(input logic [1:0] p);
        return {DEV_TYPE, ADDR_PAD, p};
    endfunction : adr

    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic wait_tap(input int pot, input logic [7:0] v);
        int n;
        for (n = 0; n < 200 && ((pot == 0) ? tap0_sel : tap1_sel) !== (256'h1 << v); n++)
            @(negedge clock);
        if (n >= 200)
        begin
            miscompares++;
            report_and_stop();
        end
        check((pot == 0) ? tap0_sel : tap1_sel, 256'h1 << v);
    endtask : wait_tap

    task automatic wait_store;
        int n;
        int hi;
        for (n = 0; n < 20 && write_pending !== 1'b1; n++)
            @(negedge clock);
        check(write_pending, 1'b1);
        for (hi = 0; hi < STC + 100 && write_pending === 1'b1; hi++)
            @(negedge clock);
        if (hi >= STC + 100)
        begin
            miscompares++;
            report_and_stop();
        end
        check(hi >= STC - 2 && hi <= STC + 5, 1'b1);
    endtask : wait_store

    initial
    begin
        #300000;
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        #2000;
        host.frame(adr(PINS), 8'hc0, 8'h3c, 24, rd);
        wait_store();
        host.frame(adr(PINS), 8'hc1, 8'hfe, 24, rd);
        wait_store();
        $display("test store_write done");
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(negedge clock);
        check(tap0_sel, 256'h1);
        wait_tap(0, 8'h3c);
        wait_tap(1, 8'hfe);
        $display("test power_up done");
        host.frame(adr(PINS), 8'hb1, 8'h00, 24, rd);
        host.frame(adr(PINS), 8'hb1, 8'h00, 24, rd);
        check(rd, 8'hfe);
        $display("test read_store done");
        host.frame(adr(PINS), 8'ha0, 8'h01, 24, rd);
        repeat (4) @(negedge clock);
        check(tap0_sel, 256'h1 << 8'h3c);
        wait_tap(0, 8'h01);
        $display("test write_wiper done");
        host.frame(adr(~PINS), 8'ha0, 8'h77, 24, rd);
        host.frame({~DEV_TYPE, ADDR_PAD, PINS}, 8'ha0, 8'h77, 24, rd);
        repeat (40) @(negedge clock);
        check(tap0_sel, 256'h1 << 8'h01);
        $display("test address_mismatch done");
        host.frame(adr(PINS), 8'h21, 8'hff, 19, rd);
        wait_tap(1, 8'hff);
        host.frame(adr(PINS), 8'h21, 8'h00, 19, rd);
        wait_tap(1, 8'hfc);
        host.frame(adr(PINS), 8'h20, 8'h00, 19, rd);
        wait_tap(0, 8'h00);
        $display("test step done");
        host.frame(adr(PINS), 8'ha0, 8'h9a, 24, rd);
        wait_tap(0, 8'h9a);
        host.frame(adr(PINS), 8'he8, 8'h00, 16, rd);
        wait_store();
        host.frame(adr(PINS), 8'ha0, 8'h55, 24, rd);
        wait_tap(0, 8'h55);
        host.frame(adr(PINS), 8'hd8, 8'h00, 16, rd);
        wait_tap(0, 8'h9a);
        $display("test copy done");
        report_and_stop();
    end
endmodule : tb
